/* shared/seqcfg_pkg.sv */
package seqcfg_pkg;

	// ****************************************
	// bus geometry
	// ****************************************
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ****************************************
	// register map: index and byte address (index times four)
	// ****************************************
	localparam logic [11:0] STEP3_CFG_INDEX = 12'h093;
	localparam logic [11:0] STEP3_CFG_ADDR = {STEP3_CFG_INDEX[9:0], 2'b00};
	localparam logic [11:0] ROUTE_STATUS_INDEX = 12'h0A0;
	localparam logic [11:0] ROUTE_STATUS_ADDR =
		{ROUTE_STATUS_INDEX[9:0], 2'b00};

	// ****************************************
	// configuration register fields
	// ****************************************
	localparam int unsigned EN_BIT = 15;
	localparam int unsigned GAIN_HI = 14;
	localparam int unsigned GAIN_LO = 13;
	localparam int unsigned NEG_BIT = 4;
	localparam int unsigned POS_HI = 3;
	localparam int unsigned POS_LO = 0;
	localparam int unsigned POS_INTERNAL_BIT = 3;
	localparam logic [15:0] CFG_RESET = 16'h0003;
	localparam logic [15:0] CFG_WRITABLE = 16'hE01F;

	// ****************************************
	// gain codes and resulting factors
	// ****************************************
	localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
	localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
	localparam logic [1:0] GAIN_CODE_X4A = 2'h2;
	localparam logic [1:0] GAIN_CODE_X4B = 2'h3;
	localparam logic [2:0] GAIN_X1 = 3'h1;
	localparam logic [2:0] GAIN_X2 = 3'h2;
	localparam logic [2:0] GAIN_X4 = 3'h4;

	// ****************************************
	// internal source indexes (positive code minus eight)
	// ****************************************
	localparam logic [2:0] SRC_TEMP_SENSOR = 3'h0;
	localparam logic [2:0] SRC_GROUND_SHORT = 3'h1;
	localparam logic [2:0] SRC_TEST_DAC = 3'h2;

	// ****************************************
	// decoded route values after reset
	// ****************************************
	localparam logic ROUTE_RST_INCLUDED = 1'b0;
	localparam logic [2:0] ROUTE_RST_GAIN = GAIN_X1;
	localparam logic ROUTE_RST_INTERNAL = 1'b0;
	localparam logic [2:0] ROUTE_RST_INDEX = 3'h3;

	// ****************************************
	// status register fields
	// ****************************************
	localparam int unsigned ST_INCLUDED_BIT = 0;
	localparam int unsigned ST_GAIN_LO = 1;
	localparam int unsigned ST_INTERNAL_BIT = 4;
	localparam int unsigned ST_NEG_AUTO_BIT = 5;
	localparam int unsigned ST_NEG_INPUT7_BIT = 6;
	localparam int unsigned ST_INDEX_LO = 8;

	// ****************************************
	// bus responses and states
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
	typedef enum logic {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;

endpackage

/* shared/step_cfg_if.sv */
`timescale 1ns/1ps
// configuration word out, decoded route back
interface step_cfg_if;
	logic [15:0] cfg;
	logic included;
	logic [2:0] gain_factor;
	logic pos_internal;
	logic [2:0] pos_index;
	logic neg_auto;
	logic neg_input7;

	modport src(
		output cfg,
		input included, gain_factor, pos_internal, pos_index,
		input neg_auto, neg_input7
	);
	modport dec(
		input cfg,
		output included, gain_factor, pos_internal, pos_index,
		output neg_auto, neg_input7
	);
endinterface

/* rtl/step_route_decode.sv */
`timescale 1ns/1ps
module step_route_decode
	import seqcfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration in, route out
	step_cfg_if.dec port
);

	logic included_q, included_d;
	logic [2:0] gain_q, gain_d;
	logic internal_q, internal_d;
	logic [2:0] index_q, index_d;
	logic neg_auto_q, neg_auto_d;
	logic neg7_q, neg7_d;

	// ****************************************
	// field decode
	// ****************************************
	always_comb begin
		included_d = port.cfg[EN_BIT];
		unique case (port.cfg[GAIN_HI:GAIN_LO])
			GAIN_CODE_X1: gain_d = GAIN_X1;
			GAIN_CODE_X2: gain_d = GAIN_X2;
			GAIN_CODE_X4A,
			GAIN_CODE_X4B: gain_d = GAIN_X4;
		endcase
		// code 8 and up selects an internal source
		internal_d = port.cfg[POS_INTERNAL_BIT];
		index_d = port.cfg[POS_LO+2:POS_LO];
		// internal source forces the negative side
		neg_auto_d = internal_d;
		neg7_d = ~internal_d & port.cfg[NEG_BIT];
	end

	// route registers
	always_ff @(posedge clk) begin
		if (rst) begin
			included_q <= ROUTE_RST_INCLUDED;
			gain_q <= ROUTE_RST_GAIN;
			internal_q <= ROUTE_RST_INTERNAL;
			index_q <= ROUTE_RST_INDEX;
			neg_auto_q <= 1'b0;
			neg7_q <= 1'b0;
		end else begin
			included_q <= included_d;
			gain_q <= gain_d;
			internal_q <= internal_d;
			index_q <= index_d;
			neg_auto_q <= neg_auto_d;
			neg7_q <= neg7_d;
		end
	end

	// drive the carrier
	assign port.included = included_q;
	assign port.gain_factor = gain_q;
	assign port.pos_internal = internal_q;
	assign port.pos_index = index_q;
	assign port.neg_auto = neg_auto_q;
	assign port.neg_input7 = neg7_q;

endmodule

/* rtl/step3_config_regs.sv */
`timescale 1ns/1ps
// What this block does
// - bit 15 set includes sequencer step three; clear skips it.
// - bits 14:13 pick gain: 00 is 1, 01 is 2, 10 and 11 are 4.
// - bit 4 picks negative input: 0 analog ground, 1 analog input seven.
// - bits 3:0 codes 0 to 7 pick external analog inputs zero to seven.
// - positive codes 8 and above route internal sources, not external inputs.
// - an internal source forces the negative input; bit 4 is then ignored.
// - register sits at index 93h and resets to 0003h.
module step3_config_regs
	import seqcfg_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// axi4-lite write data
	input wire logic [DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// axi4-lite read data
	output logic [DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// step three route to the converter front end
	output logic STEP3_INCLUDED,
	output logic [2:0] STEP3_GAIN_FACTOR,
	output logic STEP3_POS_INTERNAL,
	output logic [2:0] STEP3_POS_INDEX,
	output logic STEP3_NEG_AUTO,
	output logic STEP3_NEG_INPUT7
);

	// ****************************************
	// state
	// ****************************************
	// bus state machines
	wr_state_t wr_q, wr_d;
	rd_state_t rd_q, rd_d;

	// write capture
	logic aw_got_q, aw_got_d;
	logic w_got_q, w_got_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;

	// response payloads
	logic [1:0] bresp_q, bresp_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// the configuration word
	logic [15:0] cfg_q, cfg_d;

	// ****************************************
	// helpers
	// ****************************************
	// channel transfers and write commit
	logic aw_hit;
	logic w_hit;
	logic ar_hit;
	logic commit;

	// address decode
	logic wsel_cfg;
	logic wsel_status;
	logic rsel_cfg;
	logic rsel_status;

	// masks and read views
	logic [15:0] lane_mask;
	logic [15:0] wr_mask;
	logic [15:0] cfg_view;
	logic [DATA_W-1:0] status_view;

	step_cfg_if route();

	// decoder holds the route in its own flops
	step_route_decode u_decode (
		.clk(CORE_CLK),
		.rst(RST),
		.port(route.dec)
	);

	assign route.cfg = cfg_q;

	// ****************************************
	// handshake outputs
	// ****************************************

	// address and data each taken once per write
	// readies stay low while a response waits for bready
	assign S_AXI_AWREADY = (wr_q == WR_IDLE) & ~aw_got_q;
	assign S_AXI_WREADY = (wr_q == WR_IDLE) & ~w_got_q;
	assign S_AXI_BVALID = (wr_q == WR_RESP);
	assign S_AXI_ARREADY = (rd_q == RD_IDLE);
	assign S_AXI_RVALID = (rd_q == RD_DATA);

	// channel transfers this cycle
	assign aw_hit = S_AXI_AWVALID & S_AXI_AWREADY;
	assign w_hit = S_AXI_WVALID & S_AXI_WREADY;
	assign ar_hit = S_AXI_ARVALID & S_AXI_ARREADY;

	// ****************************************
	// register views
	// ****************************************

	// reserved field always reads zero
	assign cfg_view = cfg_q & CFG_WRITABLE;

	// decoded route as software sees it
	// lags a config write by two edges: the register, then the route
	always_comb begin
		status_view = '0;
		status_view[ST_INCLUDED_BIT] = route.included;
		status_view[ST_GAIN_LO+2:ST_GAIN_LO] = route.gain_factor;
		status_view[ST_INTERNAL_BIT] = route.pos_internal;
		status_view[ST_NEG_AUTO_BIT] = route.neg_auto;
		status_view[ST_NEG_INPUT7_BIT] = route.neg_input7;
		status_view[ST_INDEX_LO+2:ST_INDEX_LO] = route.pos_index;
	end

	// ****************************************
	// write channel
	// ****************************************

	// capture muxes, kept out of the state process below so that
	// the address decode they feed cannot loop back into it
	assign waddr_d = aw_hit ? S_AXI_AWADDR : waddr_q;
	assign wdata_d = w_hit ? S_AXI_WDATA : wdata_q;
	assign wstrb_d = w_hit ? S_AXI_WSTRB : wstrb_q;

	// address and data may arrive in either order
	always_comb begin
		aw_got_d = aw_got_q | aw_hit;
		w_got_d = w_got_q | w_hit;
		bresp_d = bresp_q;
		wr_d = wr_q;
		commit = 1'b0;
		unique case (wr_q)
			WR_IDLE: begin
				if (aw_got_d & w_got_d) begin
					commit = 1'b1;
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
					wr_d = WR_RESP;
					// status is read only; anything else is not decoded
					if (wsel_cfg) begin
						bresp_d = RESP_OKAY;
					end else if (wsel_status) begin
						bresp_d = RESP_SLVERR;
					end else begin
						bresp_d = RESP_DECERR;
					end
				end
			end
			WR_RESP: begin
				if (S_AXI_BREADY) begin
					wr_d = WR_IDLE;
				end
			end
		endcase
	end

	// word decode of the write address
	// the low two address bits are ignored: one aligned word each
	assign wsel_cfg = (waddr_d[ADDR_W-1:2] == STEP3_CFG_ADDR[ADDR_W-1:2]);
	assign wsel_status =
		(waddr_d[ADDR_W-1:2] == ROUTE_STATUS_ADDR[ADDR_W-1:2]);

	// byte lanes 0 and 1 cover the sixteen bits
	assign lane_mask = {{8{wstrb_d[1]}}, {8{wstrb_d[0]}}};

	// only the documented fields take write data
	assign wr_mask = lane_mask & CFG_WRITABLE;

	// configuration register update
	// reserved bits never reach the flops, so they read back zero
	always_comb begin
		cfg_d = cfg_q;
		if (commit & wsel_cfg) begin
			cfg_d = (cfg_q & ~wr_mask) | (wdata_d[15:0] & wr_mask);
		end
	end

	// write side registers
	// a half that came alone waits here for its partner
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wr_q <= WR_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= 4'h0;
			bresp_q <= RESP_OKAY;
		end else begin
			wr_q <= wr_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bresp_q <= bresp_d;
		end
	end

	// configuration register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			cfg_q <= CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ****************************************
	// read channel
	// ****************************************

	// word decode of the read address
	// low two address bits ignored here as well
	assign rsel_cfg = (S_AXI_ARADDR[ADDR_W-1:2] == STEP3_CFG_ADDR[ADDR_W-1:2]);
	assign rsel_status =
		(S_AXI_ARADDR[ADDR_W-1:2] == ROUTE_STATUS_ADDR[ADDR_W-1:2]);

	// data latched when the address is taken
	// a write landing on the same edge shows in the next read
	always_comb begin
		rd_d = rd_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		unique case (rd_q)
			RD_IDLE: begin
				if (ar_hit) begin
					rd_d = RD_DATA;
					if (rsel_cfg) begin
						rdata_d = {16'h0000, cfg_view};
						rresp_d = RESP_OKAY;
					end else if (rsel_status) begin
						rdata_d = status_view;
						rresp_d = RESP_OKAY;
					end else begin
						rdata_d = '0;
						rresp_d = RESP_DECERR;
					end
				end
			end
			RD_DATA: begin
				if (S_AXI_RREADY) begin
					rd_d = RD_IDLE;
				end
			end
		endcase
	end

	// read side registers
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rd_q <= RD_IDLE;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			rd_q <= rd_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	// bus payloads from flops
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	// route to the converter front end
	// each stands until the register changes, one edge behind it
	assign STEP3_INCLUDED = route.included;
	assign STEP3_GAIN_FACTOR = route.gain_factor;
	assign STEP3_POS_INTERNAL = route.pos_internal;
	assign STEP3_POS_INDEX = route.pos_index;
	assign STEP3_NEG_AUTO = route.neg_auto;
	assign STEP3_NEG_INPUT7 = route.neg_input7;

endmodule

/* testbench/step3_checker.sv */
`timescale 1ns/1ps
module step3_checker
	import seqcfg_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// bus handshakes
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// bus payloads
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic [DATA_W-1:0] S_AXI_WDATA,
	input wire logic [DATA_W-1:0] S_AXI_RDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic [1:0] S_AXI_RRESP,
	// route outputs
	input wire logic STEP3_INCLUDED,
	input wire logic [2:0] STEP3_GAIN_FACTOR,
	input wire logic STEP3_POS_INTERNAL,
	input wire logic [2:0] STEP3_POS_INDEX,
	input wire logic STEP3_NEG_AUTO,
	input wire logic STEP3_NEG_INPUT7
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	// ****
	// write steps: both halves taken, with a config lane hit in that same cycle
	// ****
	sequence aw_w_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence cfg_hit(int ln);
		aw_w_taken ##0 (S_AXI_AWADDR == STEP3_CFG_ADDR && S_AXI_WSTRB[ln]);
	endsequence

	// ****
	// route follows writes two edges later
	// ****
	a_incl_follow: assert property (cfg_hit(1) |=> ##1
		STEP3_INCLUDED == $past(S_AXI_WDATA[15], 2))
		else $error("included flag wrong");
	a_gain_decode: assert property (cfg_hit(1) |=> ##1
		STEP3_GAIN_FACTOR == ($past(S_AXI_WDATA[14], 2) ? GAIN_X4 :
		$past(S_AXI_WDATA[13], 2) ? GAIN_X2 : GAIN_X1))
		else $error("gain factor wrong");
	a_neg_select: assert property (cfg_hit(0) |=> ##1
		STEP3_NEG_INPUT7 == $past(S_AXI_WDATA[4] & ~S_AXI_WDATA[3], 2))
		else $error("negative select wrong");
	a_pos_select: assert property (cfg_hit(0) |=> ##1
		{STEP3_POS_INTERNAL, STEP3_POS_INDEX} == $past(S_AXI_WDATA[3:0], 2))
		else $error("positive select wrong");
	a_neg_forced: assert property (STEP3_POS_INTERNAL |->
		STEP3_NEG_AUTO && !STEP3_NEG_INPUT7)
		else $error("negative input not forced");
	a_reset_route: assert property (disable iff (1'b0) RST |=>
		!STEP3_INCLUDED && STEP3_GAIN_FACTOR == GAIN_X1 &&
		STEP3_POS_INDEX == 3'h3 && !STEP3_POS_INTERNAL && !STEP3_NEG_INPUT7)
		else $error("route not at reset values");
	a_rsv_zero: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR == STEP3_CFG_ADDR |=> S_AXI_RRESP == RESP_OKAY &&
		S_AXI_RDATA[31:16] == 16'h0000 && S_AXI_RDATA[12:5] == 8'h00)
		else $error("reserved bits not zero");

	// ****
	// bus timing
	// ****
	a_b_next: assert property (aw_w_taken |=> S_AXI_BVALID)
		else $error("write response late");
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_unmapped_rd: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR != STEP3_CFG_ADDR && S_AXI_ARADDR != ROUTE_STATUS_ADDR
		|=> S_AXI_RRESP == RESP_DECERR && S_AXI_RDATA == 32'h00000000)
		else $error("unmapped read not refused");
endmodule

bind step3_config_regs step3_checker i_step3_checker (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_AWADDR(S_AXI_AWADDR),
	.S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_WDATA(S_AXI_WDATA),
	.S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_WSTRB(S_AXI_WSTRB),
	.S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_RRESP(S_AXI_RRESP),
	.STEP3_INCLUDED(STEP3_INCLUDED),
	.STEP3_GAIN_FACTOR(STEP3_GAIN_FACTOR),
	.STEP3_POS_INTERNAL(STEP3_POS_INTERNAL),
	.STEP3_POS_INDEX(STEP3_POS_INDEX),
	.STEP3_NEG_AUTO(STEP3_NEG_AUTO),
	.STEP3_NEG_INPUT7(STEP3_NEG_INPUT7)
);

/* testbench/adc_sequencer_step3_config_tb_top.sv */
`timescale 1ns/1ps
module adc_sequencer_step3_config_tb_top
	import seqcfg_pkg::*;
;
	typedef struct {logic [15:0] wd; logic [15:0] rb; logic [9:0] rt;} row_t;
	// written word, readback, packed route
	row_t rows [7] = '{'{16'h8000, 16'h8000, 10'h240},
		'{16'h2017, 16'h2017, 10'h09D}, '{16'hC018, 16'hC018, 10'h322},
		'{16'hFFFF, 16'hE01F, 10'h33E}, '{16'h0009, 16'h0009, 10'h066},
		'{16'h001A, 16'h001A, 10'h06A}, '{16'h8014, 16'h8014, 10'h251}};
	logic CORE_CLK = 1'b0;
	logic RST = 1'b1;
	logic [ADDR_W-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic [DATA_W-1:0] S_AXI_WDATA = '0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = '0;
	logic [2:0] S_AXI_AWPROT = '0, S_AXI_ARPROT = '0;
	logic [2:0] STEP3_GAIN_FACTOR, STEP3_POS_INDEX;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic STEP3_INCLUDED, STEP3_POS_INTERNAL, STEP3_NEG_AUTO, STEP3_NEG_INPUT7;
	logic [31:0] rdat;
	int n_errors = 0;
	int n_checks = 0;

	step3_config_regs i_step3_config_regs (
		.CORE_CLK(CORE_CLK),
		.RST(RST),
		.S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWPROT(S_AXI_AWPROT),
		.S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARPROT(S_AXI_ARPROT),
		.S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY),
		.STEP3_INCLUDED(STEP3_INCLUDED),
		.STEP3_GAIN_FACTOR(STEP3_GAIN_FACTOR),
		.STEP3_POS_INTERNAL(STEP3_POS_INTERNAL),
		.STEP3_POS_INDEX(STEP3_POS_INDEX),
		.STEP3_NEG_AUTO(STEP3_NEG_AUTO),
		.STEP3_NEG_INPUT7(STEP3_NEG_INPUT7)
	);

	// 40 MHz clock
	always #12.5 CORE_CLK = ~CORE_CLK;

	// ****
	// helpers
	// ****
	function automatic logic [31:0] route();
		return 32'({STEP3_INCLUDED, STEP3_GAIN_FACTOR, STEP3_POS_INTERNAL,
			STEP3_POS_INDEX, STEP3_NEG_AUTO, STEP3_NEG_INPUT7});
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// write with response ready held off for dl cycles
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er, input int dl);
		int n;
		logic pa, pw, ok;
		n = 0;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge CORE_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= (dl == 0);
		while (pa || pw) begin
			@(posedge CORE_CLK);
			if (pa && S_AXI_AWREADY) begin
				pa = 1'b0;
				S_AXI_AWVALID <= 1'b0;
			end
			if (pw && S_AXI_WREADY) begin
				pw = 1'b0;
				S_AXI_WVALID <= 1'b0;
			end
		end
		do begin
			@(posedge CORE_CLK);
			ok = S_AXI_BVALID && S_AXI_BREADY;
			n++;
			if (!ok && n >= dl) S_AXI_BREADY <= 1'b1;
		end while (!ok);
		S_AXI_BREADY <= 1'b0;
		chk("bresp", 32'(S_AXI_BRESP), 32'(er));
	endtask
	// read into rdat with data ready held off for dl cycles
	task automatic rd(input logic [11:0] a, input int dl, input logic [1:0] er);
		int n;
		logic ok;
		n = 0;
		@(posedge CORE_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= (dl == 0);
		do @(posedge CORE_CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do begin
			@(posedge CORE_CLK);
			ok = S_AXI_RVALID && S_AXI_RREADY;
			n++;
			if (!ok && n >= dl) S_AXI_RREADY <= 1'b1;
		end while (!ok);
		S_AXI_RREADY <= 1'b0;
		rdat = S_AXI_RDATA;
		chk("rresp", 32'(S_AXI_RRESP), 32'(er));
	endtask
	// ten cycles of reset, then reset values
	task automatic do_reset();
		RST <= 1'b1;
		repeat (10) @(posedge CORE_CLK);
		chk("reset route", route(), 32'h0000004C);
		RST <= 1'b0;
		rd(STEP3_CFG_ADDR, 0, RESP_OKAY);
		chk("reset cfg", rdat, 32'h00000003);
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		do_reset();
		for (int i = 0; i < 7; i++) begin
			wr(STEP3_CFG_ADDR, {16'hA5A5, rows[i].wd}, 4'hF, RESP_OKAY, i % 3);
			rd(STEP3_CFG_ADDR, i % 2, RESP_OKAY);
			chk("cfg", rdat, {16'h0000, rows[i].rb});
			chk("route", route(), 32'(rows[i].rt));
		end
		wr(STEP3_CFG_ADDR, 32'h00006FF5, 4'h1, RESP_OKAY, 0);
		rd(STEP3_CFG_ADDR, 0, RESP_OKAY);
		chk("lane0 write", rdat, 32'h00008015);
		rd(ROUTE_STATUS_ADDR, 2, RESP_OKAY);
		chk("status", rdat, 32'h00000543);
		wr(ROUTE_STATUS_ADDR, 32'h00000000, 4'hF, RESP_SLVERR, 1);
		wr(12'h248, 32'h00000000, 4'hF, RESP_DECERR, 0);
		rd(12'h248, 0, RESP_DECERR);
		chk("unmapped", rdat, 32'h00000000);
		rd(STEP3_CFG_ADDR, 0, RESP_OKAY);
		chk("kept cfg", rdat, 32'h00008015);
		chk("kept route", route(), 32'h00000255);
		do_reset();
		report_and_stop();
	end

	// hang guard
	initial begin
		repeat (4000) @(posedge CORE_CLK);
		n_errors++;
		report_and_stop();
	end
endmodule
